// ===== aos_sync.sv
`timescale 1ns/1ps
`default_nettype none

package aos_pkg;
    // Sample path
    localparam int WORD_W        = 14;
    localparam int PIPE_DEPTH    = 4;
    // Output turn-on delay
    localparam int CLK_PERIOD_NS = 10;
    localparam int TON_NS        = 1;
    localparam int TON_RAW       = TON_NS / CLK_PERIOD_NS;
    localparam int TON_CYC       = (TON_RAW < 1) ? 1 : TON_RAW;
    localparam int TON_W         = 4;
    // Pin synchroniser
    localparam int PIN_W         = 2;
    localparam int PIN_DIS       = 0;
    localparam int PIN_CODE      = 1;
    localparam logic [PIN_W-1:0] PIN_RST = 2'h3;
    // Register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL        = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS      = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE  = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR   = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_LAST_WORD   = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_RANGE_COUNT = 8'h18;
    // Control fields
    localparam int CTRL_W        = 3;
    localparam int CTRL_FORCE    = 0;
    localparam int CTRL_CODE_OVR = 1;
    localparam int CTRL_CODE_VAL = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    // Status fields
    localparam int STAT_W     = 3;
    localparam int STAT_OE    = 0;
    localparam int STAT_CODE  = 1;
    localparam int STAT_RANGE = 2;
    // Interrupt fields
    localparam int IRQ_W     = 3;
    localparam int IRQ_RANGE = 0;
    localparam int IRQ_ON    = 1;
    localparam int IRQ_OFF   = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
    // Out-of-range counter
    localparam int CNT_W = 16;

    typedef enum logic [1:0]
    {
        AOS_OE_OFF  = 2'b00,
        AOS_OE_WAIT = 2'b01,
        AOS_OE_ON   = 2'b10
    } aos_oe_t;
endpackage

module aos_sync #(
    parameter int                WIDTH   = aos_pkg::PIN_W,
    parameter logic [WIDTH-1:0]  RST_VAL = aos_pkg::PIN_RST
) (
    // Clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import aos_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } aos_sync_t;

    aos_sync_t st;
    aos_sync_t next_st;

    // Change accepted once second and third stage agree
    always_comb
    begin
        next_st    = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st.s2[i] == st.s3[i])
            begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end
        else if (ce_in)
        begin
            st <= next_st;
        end
    end

    assign sync_out = st.q;
endmodule

`default_nettype wire

// ===== aos_top.sv
`timescale 1ns/1ps
`default_nettype none

module aos_top #(
    parameter int WORD_W     = aos_pkg::WORD_W,
    parameter int PIPE_DEPTH = aos_pkg::PIPE_DEPTH
) (
    // Clock, reset, enable
    input  wire logic                       clock_in,
    input  wire logic                       rst_in,
    input  wire logic                       ce_in,
    // Converter core
    input  wire logic [WORD_W-1:0]          conv_word_in,
    // Pins
    input  wire logic                       coding_select_n_in,
    input  wire logic                       output_disable_in,
    // Output bus
    output logic      [WORD_W-1:0]          sample_word_out,
    output logic                            sample_word_oe_out,
    output logic                            range_flag_out,
    output logic                            range_flag_oe_out,
    output logic                            sample_valid_strobe_out,
    output logic                            sample_valid_strobe_oe_out,
    // APB slave
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [aos_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]                pwdata_in,
    output logic      [31:0]                prdata_out,
    output logic                            pready_out,
    output logic                            pslverr_out,
    // Interrupt
    output logic                            irq_out
);
    import aos_pkg::*;

    localparam logic [WORD_W-1:0] MSB_MASK = {1'b1, {(WORD_W - 1){1'b0}}};

    typedef struct packed {
        logic [PIPE_DEPTH-1:0][WORD_W-1:0] pipe;
        aos_oe_t                           oe;
        logic [TON_W-1:0]                  ton_cnt;
        logic [CTRL_W-1:0]                 ctrl;
        logic [IRQ_W-1:0]                  irq_status;
        logic [IRQ_W-1:0]                  irq_enable;
        logic [CNT_W-1:0]                  range_count;
        logic [31:0]                       rdata;
        logic                              slverr;
    } aos_state_t;

    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic              coding_bin;
        logic              flag;
    } aos_out_t;

    aos_state_t        st;
    aos_state_t        next_st;
    aos_out_t          ost;
    aos_out_t          next_ost;
    logic [PIN_W-1:0]  pins_raw;
    logic [PIN_W-1:0]  pins_sync;
    logic              dis_eff;
    logic              coding_bin;
    logic [WORD_W-1:0] tail_word;
    logic              tail_out_of_range;
    logic              setup_phase;
    logic              access_phase;
    logic              addr_ok;

    // Pin inputs pass the three-stage synchroniser
    assign pins_raw[PIN_DIS]  = output_disable_in;
    assign pins_raw[PIN_CODE] = coding_select_n_in;

    aos_sync #(
        .WIDTH   (PIN_W),
        .RST_VAL (PIN_RST)
    ) u_pin_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .ce_in    (ce_in),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    assign dis_eff    = pins_sync[PIN_DIS] | st.ctrl[CTRL_FORCE];
    assign coding_bin = st.ctrl[CTRL_CODE_OVR] ? st.ctrl[CTRL_CODE_VAL] : pins_sync[PIN_CODE];

    // Word leaving the pipeline and its range check
    assign tail_word         = st.pipe[PIPE_DEPTH-1];
    assign tail_out_of_range = (&tail_word) | ~(|tail_word);

    assign setup_phase  = psel_in & ~penable_in;
    assign access_phase = psel_in & penable_in & ce_in;

    always_comb
    begin
        case (paddr_in)
            ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE,
            ADDR_IRQ_CLEAR, ADDR_LAST_WORD, ADDR_RANGE_COUNT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Rising-edge state: pipeline, output enable sequencing, registers
    always_comb
    begin
        logic [IRQ_W-1:0] events;
        logic [IRQ_W-1:0] clear;
        events  = '0;
        clear   = '0;
        next_st = st;

        // Sampling goes on whatever the output enable; it stops only while ce_in is low
        next_st.pipe[0] = conv_word_in;
        for (int i = 1; i < PIPE_DEPTH; i++)
        begin
            next_st.pipe[i] = st.pipe[i-1];
        end

        case (st.oe)
            AOS_OE_OFF:
            begin
                if (!dis_eff)
                begin
                    next_st.oe      = AOS_OE_WAIT;
                    next_st.ton_cnt = TON_W'(TON_CYC - 1);
                end
            end
            AOS_OE_WAIT:
            begin
                if (dis_eff)
                begin
                    next_st.oe = AOS_OE_OFF;
                end
                else if (st.ton_cnt == '0)
                begin
                    next_st.oe       = AOS_OE_ON;
                    events[IRQ_ON]   = 1'b1;
                end
                else
                begin
                    next_st.ton_cnt = st.ton_cnt - 1'b1;
                end
            end
            AOS_OE_ON:
            begin
                if (dis_eff)
                begin
                    next_st.oe      = AOS_OE_OFF;
                    events[IRQ_OFF] = 1'b1;
                end
            end
            default:
            begin
                next_st.oe = AOS_OE_OFF;
            end
        endcase

        if (tail_out_of_range)
        begin
            events[IRQ_RANGE] = 1'b1;
            if (st.range_count != '1)
            begin
                next_st.range_count = st.range_count + 1'b1;
            end
        end

        // Read data and error are prepared in the setup phase
        if (setup_phase)
        begin
            next_st.slverr = ~addr_ok;
            next_st.rdata  = '0;
            case (paddr_in)
                ADDR_CTRL:        next_st.rdata[CTRL_W-1:0] = st.ctrl;
                ADDR_STATUS:
                begin
                    next_st.rdata[STAT_OE]    = (st.oe == AOS_OE_ON);
                    next_st.rdata[STAT_CODE]  = ost.coding_bin;
                    next_st.rdata[STAT_RANGE] = ost.flag;
                end
                ADDR_IRQ_STATUS:  next_st.rdata[IRQ_W-1:0]  = st.irq_status;
                ADDR_IRQ_ENABLE:  next_st.rdata[IRQ_W-1:0]  = st.irq_enable;
                ADDR_LAST_WORD:   next_st.rdata[WORD_W-1:0] = ost.word;
                ADDR_RANGE_COUNT: next_st.rdata[CNT_W-1:0]  = st.range_count;
                default:          next_st.rdata             = '0;
            endcase
        end

        // Writes take effect in the access phase
        if (access_phase && pwrite_in)
        begin
            case (paddr_in)
                ADDR_CTRL:       next_st.ctrl       = pwdata_in[CTRL_W-1:0];
                ADDR_IRQ_ENABLE: next_st.irq_enable = pwdata_in[IRQ_W-1:0];
                ADDR_IRQ_CLEAR:  clear              = pwdata_in[IRQ_W-1:0];
                default:         clear              = '0;
            endcase
        end

        // A new event wins over a clear in the same cycle
        next_st.irq_status = (st.irq_status & ~clear) | events;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st             <= '0;
            st.oe          <= AOS_OE_OFF;
            st.ctrl        <= CTRL_RST;
            st.irq_status  <= IRQ_RST;
            st.irq_enable  <= IRQ_RST;
        end
        else if (ce_in)
        begin
            st <= next_st;
        end
    end

    // Falling-edge output register: word, its coding and its flag travel together
    always_comb
    begin
        next_ost            = ost;
        next_ost.coding_bin = coding_bin;
        next_ost.flag       = tail_out_of_range;
        if (coding_bin)
        begin
            next_ost.word = tail_word;
        end
        else
        begin
            next_ost.word = tail_word ^ MSB_MASK;
        end
    end

    always_ff @(negedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ost <= '0;
        end
        else if (ce_in)
        begin
            ost <= next_ost;
        end
    end

    // Pins: drivers are enabled together
    assign sample_word_out            = ost.word;
    assign range_flag_out             = ost.flag;
    assign sample_valid_strobe_out    = clock_in & ce_in;
    assign sample_word_oe_out         = (st.oe == AOS_OE_ON) & ~dis_eff;
    assign range_flag_oe_out          = sample_word_oe_out;
    assign sample_valid_strobe_oe_out = sample_word_oe_out;

    // APB answer
    assign pready_out  = access_phase;
    assign pslverr_out = access_phase & st.slverr;
    assign prdata_out  = st.rdata;
    assign irq_out     = |(st.irq_status & st.irq_enable);

    // Enable history used by the checks below
    logic [PIPE_DEPTH+1:0] ce_hist;
    logic                  ce_steady;

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ce_hist <= '0;
        end
        else
        begin
            ce_hist <= {ce_hist[PIPE_DEPTH:0], ce_in};
        end
    end

    assign ce_steady = (&ce_hist) & ce_in;

    coding_twos_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (ce_steady && !ost.coding_bin) |->
            sample_word_out == ($past(conv_word_in, PIPE_DEPTH) ^ MSB_MASK))
        else $error("two's complement word does not match sample");

    coding_binary_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (ce_steady && ost.coding_bin) |->
            sample_word_out == $past(conv_word_in, PIPE_DEPTH))
        else $error("straight binary word does not match sample");

    msb_only_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        ce_steady |->
            (sample_word_out[WORD_W-2:0] == $past(conv_word_in[WORD_W-2:0], PIPE_DEPTH)))
        else $error("coding changed more than the top bit");

    fixed_latency_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (ce_steady && ost.coding_bin && $past(ost.coding_bin)) |->
            (sample_word_out == $past(conv_word_in, PIPE_DEPTH)) &&
            ($past(sample_word_out) == $past(conv_word_in, PIPE_DEPTH + 1)))
        else $error("sample latency is not constant");

    range_flag_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        ce_steady |->
            range_flag_out == ((~|$past(conv_word_in, PIPE_DEPTH)) ||
                               (&$past(conv_word_in, PIPE_DEPTH))))
        else $error("range flag does not match the word");

    drive_enabled_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        ((!dis_eff && ce_in) [*3]) |->
            sample_word_oe_out && range_flag_oe_out && sample_valid_strobe_oe_out)
        else $error("outputs not driven while enabled");

    hiz_disabled_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        dis_eff |-> !sample_word_oe_out && !range_flag_oe_out ##1 (!$past(ce_in) || st.oe == AOS_OE_OFF))
        else $error("output driven while disabled");

    strobe_hiz_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        $rose(dis_eff) |-> !sample_valid_strobe_oe_out ##1
            (!dis_eff || !sample_valid_strobe_oe_out))
        else $error("strobe driven while disabled");

    turn_on_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        ($fell(dis_eff) && ce_in) ##1 (!dis_eff && ce_in) ##1 !dis_eff |->
            !$past(sample_word_oe_out, 2) && !$past(sample_word_oe_out) && sample_word_oe_out)
        else $error("turn-on delay not met");

    keep_sampling_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (dis_eff && ce_in) |=> st.pipe[0] == $past(conv_word_in))
        else $error("sampling stopped while disabled");

endmodule

`default_nettype wire

// ===== aos_capture.sv
`timescale 1ns/1ps
`default_nettype none

module aos_capture #(
    parameter int WORD_W = 14
) (
    // Clock
    input  wire logic              clock_in,
    // Block outputs
    input  wire logic [WORD_W-1:0] word_in,
    input  wire logic              word_oe_in,
    input  wire logic              flag_in,
    input  wire logic              flag_oe_in,
    input  wire logic              strobe_in,
    input  wire logic              strobe_oe_in,
    // Resolved lines and capture count
    output logic      [WORD_W-1:0] bus_word_out,
    output logic                   bus_flag_out,
    output logic                   bus_strobe_out,
    output logic      [31:0]       cap_count_out
);
    logic [WORD_W-1:0] last_word = '0;
    logic              last_flag = 1'b0;
    logic              junk      = 1'b0;
    logic [31:0]       count     = 32'h0;

    // Released word and flag lines show the inverse of their last level; a released strobe toggles every clock
    always @(posedge clock_in)
    begin
        junk <= ~junk;
        if (word_oe_in)
            last_word <= word_in;
        if (flag_oe_in)
            last_flag <= flag_in;
    end

    assign bus_word_out   = word_oe_in ? word_in : ~last_word;
    assign bus_flag_out   = flag_oe_in ? flag_in : ~last_flag;
    assign bus_strobe_out = strobe_oe_in ? strobe_in : junk;
    assign cap_count_out  = count;

    // Count each rising strobe while the strobe is driven
    always @(posedge bus_strobe_out)
    begin
        if (strobe_oe_in)
            count <= count + 32'h1;
    end
endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import aos_pkg::*;

    logic              clock_in           = 1'b0;
    logic              rst_in             = 1'b1;
    logic              ce_in              = 1'b1;
    logic              output_disable_in  = 1'b0;
    logic              coding_select_n_in = 1'b1;
    logic [WORD_W-1:0] conv_word_in       = '0;
    logic              psel_in            = 1'b0;
    logic              penable_in         = 1'b0;
    logic              pwrite_in          = 1'b0;
    logic [ADDR_W-1:0] paddr_in           = '0;
    logic [31:0]       pwdata_in          = 32'h0;
    logic [WORD_W-1:0] word_out;
    logic              word_oe;
    logic              flag_out;
    logic              flag_oe;
    logic              strobe_out;
    logic              strobe_oe;
    logic [31:0]       prdata_out;
    logic              pready_out;
    logic              pslverr_out;
    logic              irq_out;
    logic [WORD_W-1:0] bus_word;
    logic              bus_flag;
    logic              bus_strobe;
    logic [31:0]       cap_count;
    logic [31:0]       cap0;
    int                miscompares = 0;
    int                compares    = 0;
    logic              chk_en      = 1'b0;
    logic              cur_code    = 1'b1;
    logic              mix_oor     = 1'b0;
    logic [WORD_W-1:0] hist[$];
    logic [WORD_W-1:0] exp_w;
    logic [WORD_W-1:0] held;
    logic              exp_f;
    logic [31:0]       rdata;
    logic              rerr;

    aos_top u_dut (
        .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in), .conv_word_in(conv_word_in),
        .coding_select_n_in(coding_select_n_in), .output_disable_in(output_disable_in),
        .sample_word_out(word_out), .sample_word_oe_out(word_oe), .range_flag_out(flag_out),
        .range_flag_oe_out(flag_oe), .sample_valid_strobe_out(strobe_out),
        .sample_valid_strobe_oe_out(strobe_oe), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out)
    );

    aos_capture u_far (
        .clock_in(clock_in), .word_in(word_out), .word_oe_in(word_oe), .flag_in(flag_out),
        .flag_oe_in(flag_oe), .strobe_in(strobe_out), .strobe_oe_in(strobe_oe),
        .bus_word_out(bus_word), .bus_flag_out(bus_flag), .bus_strobe_out(bus_strobe),
        .cap_count_out(cap_count)
    );

    always #5 clock_in = ~clock_in;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
        compares++;
        if (seen !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
            miscompares++;
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Converter words, all-zero and all-one words mixed in on request
    always @(posedge clock_in)
    begin
        if (mix_oor && $urandom_range(0, 1) == 0)
            conv_word_in <= {WORD_W{1'($urandom_range(0, 1))}};
        else
            conv_word_in <= WORD_W'($urandom_range(1, 32'h3FFE));
    end

    // Reference pipeline compared with the bus at each rising edge while checking is on and the word is driven
    always @(posedge clock_in)
    begin
        if (rst_in)
            hist.delete();
        else
        begin
            if (ce_in)
                hist.push_back(conv_word_in);
            if (hist.size() > PIPE_DEPTH + 1)
                void'(hist.pop_front());
            if (chk_en && hist.size() == PIPE_DEPTH + 1 && word_oe === 1'b1)
            begin
                exp_w = hist[0];
                exp_f = (exp_w == '0) || (exp_w == '1);
                if (!cur_code)
                    exp_w[WORD_W-1] = ~exp_w[WORD_W-1];
                check("word", 32'(bus_word), 32'(exp_w));
                check("range_flag", 32'(bus_flag), 32'(exp_f));
            end
        end
    end

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= wr;
        paddr_in   <= a;
        pwdata_in  <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        @(posedge clock_in);
        while (pready_out !== 1'b1 && n < 16)
        begin
            @(posedge clock_in);
            n++;
        end
        rdata = prdata_out;
        rerr  = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        if (n == 16)
        begin
            check("pready", 32'(pready_out), 32'h1);
            wrap_up();
        end
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, rdata, e);
    endtask

    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        while (word_oe !== v && n < 16)
        begin
            @(posedge clock_in);
            n++;
        end
        check("word_oe", 32'(word_oe), 32'(v));
        check("flag_oe", 32'(flag_oe), 32'(v));
        check("strobe_oe", 32'(strobe_oe), 32'(v));
        if (n == 16)
            wrap_up();
    endtask

    initial
    begin
        #400000;
        check("watchdog", 32'h0, 32'h1);
        wrap_up();
    end

    initial
    begin
        void'($urandom(32'h7DDA));
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        wait_oe(1'b1);
        chk_en <= 1'b1;
        rd(ADDR_CTRL, 32'h0, "ctrl");
        rd(ADDR_IRQ_ENABLE, 32'h0, "irq_enable");
        rd(8'h40, 32'h0, "unmapped");
        check("unmapped_err", 32'(rerr), 32'h1);
        // Both codings, switched while converting
        for (int c = 1; c >= 0; c--)
        begin
            chk_en             <= 1'b0;
            coding_select_n_in <= c[0];
            repeat (10) @(posedge clock_in);
            cur_code <= c[0];
            chk_en   <= 1'b1;
            mix_oor  <= 1'b1;
            repeat (60) @(posedge clock_in);
        end
        // Enable dropped at random: the bus holds its word while frozen
        repeat (40)
        begin
            ce_in <= 1'($urandom_range(0, 1));
            @(posedge clock_in);
        end
        ce_in <= 1'b1;
        // Sticky range event, masked then enabled, then cleared
        mix_oor <= 1'b0;
        repeat (8) @(posedge clock_in);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h7);
        rd(ADDR_IRQ_STATUS, 32'h0, "irq_status");
        mix_oor <= 1'b1;
        repeat (20) @(posedge clock_in);
        mix_oor <= 1'b0;
        repeat (8) @(posedge clock_in);
        rd(ADDR_IRQ_STATUS, 32'h1, "irq_status");
        check("irq_masked", 32'(irq_out), 32'h0);
        rd(ADDR_STATUS, 32'h1, "status");
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h7);
        @(posedge clock_in);
        check("irq_raised", 32'(irq_out), 32'h1);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h1);
        @(posedge clock_in);
        check("irq_cleared", 32'(irq_out), 32'h0);
        // Outputs released through the control register
        apb(1'b1, ADDR_CTRL, 32'h1);
        rd(ADDR_CTRL, 32'h1, "ctrl");
        wait_oe(1'b0);
        rd(ADDR_IRQ_STATUS, 32'h4, "irq_status");
        apb(1'b1, ADDR_CTRL, 32'h0);
        wait_oe(1'b1);
        // Outputs released through the pin while sampling goes on
        output_disable_in <= 1'b1;
        wait_oe(1'b0);
        repeat (30) @(posedge clock_in);
        output_disable_in <= 1'b0;
        wait_oe(1'b1);
        cap0 = cap_count;
        repeat (20) @(posedge clock_in);
        check("captures", cap_count - cap0, 32'h14);
        // Strobe follows the clock, word stands through the high phase
        @(posedge clock_in);
        #2;
        held = bus_word;
        check("strobe_high", 32'(bus_strobe), 32'h1);
        #2;
        check("word_held", 32'(bus_word), 32'(held));
        #4;
        check("strobe_low", 32'(bus_strobe), 32'h0);
        wrap_up();
    end
endmodule

`default_nettype wire
